// File: hw/pdirq_defines.svh
// register offsets, field positions and reset values of the interrupt status/enable block
`ifndef PDIRQ_DEFINES_SVH
`define PDIRQ_DEFINES_SVH

`define PDIRQ_OFS_RX_ERR_STAT   16'h1a83
`define PDIRQ_OFS_PM_STAT       16'h1a84
`define PDIRQ_OFS_FS_STAT       16'h1a85
`define PDIRQ_OFS_TX_EN         16'h1a86
`define PDIRQ_OFS_RX_EN         16'h1a87
`define PDIRQ_OFS_RX_ERR_EN     16'h1a88
`define PDIRQ_OFS_PM_EN         16'h1a89
`define PDIRQ_OFS_FS_EN         16'h1a8a

`define PDIRQ_MASK_PM_STAT      8'h01
`define PDIRQ_MASK_FS           8'h1f
`define PDIRQ_MASK_TX_EN        8'hff
`define PDIRQ_MASK_RX_EN        8'hef
`define PDIRQ_MASK_RX_ERR       8'h8f
`define PDIRQ_MASK_PM_EN        8'h0d

`define PDIRQ_BIT_ACT_WAKE      0
`define PDIRQ_BIT_WAKE_REQ_EN   2
`define PDIRQ_BIT_STOP_REQ_EN   3
`define PDIRQ_BIT_DEBUG_EVT     7
`define PDIRQ_FS_WIDTH          5
`define PDIRQ_ERR_EVT_WIDTH     4

`define PDIRQ_RST_VAL           8'h00

`endif

// File: hw/pdirq_pkg.sv
// types shared by the interrupt status/enable block
package pdirq_pkg;
   typedef logic [7:0]  pdirq_byte_t;
   typedef logic [15:0] pdirq_addr_t;
   typedef enum logic [2:0] {
      PDIRQ_SEL_NONE   = 3'b000,
      PDIRQ_SEL_ERR_ST = 3'b001,
      PDIRQ_SEL_PM_ST  = 3'b010,
      PDIRQ_SEL_FS_ST  = 3'b011,
      PDIRQ_SEL_TX_EN  = 3'b100,
      PDIRQ_SEL_RX_EN  = 3'b101,
      PDIRQ_SEL_ERR_EN = 3'b110,
      PDIRQ_SEL_PM_EN  = 3'b111
   } pdirq_sel_t;
endpackage : pdirq_pkg

// File: hw/pdirq_async_flag.sv
// sticky flag with asynchronous set and synchronous write-one-to-clear
`timescale 1ns/1ps
module pdirq_async_flag (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic set_async,
   input  wire logic clear,
   output logic      flag_r
);
   // set is an asynchronous preset; it wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n or posedge set_async) begin
      if (!rst_n) begin
         flag_r <= 1'b0;
      end else if (set_async) begin
         flag_r <= 1'b1;
      end else if (clear) begin
         flag_r <= 1'b0;
      end
   end
endmodule : pdirq_async_flag

// File: hw/pdirq_top.sv
// interrupt status and enable registers of the power-delivery mac
`timescale 1ns/1ps
`include "pdirq_defines.svh"
module pdirq_top (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire pdirq_pkg::pdirq_addr_t   host_addr,
   input  wire pdirq_pkg::pdirq_byte_t   host_wdata,
   input  wire logic                     host_wr,
   input  wire logic                     host_rd,
   output pdirq_pkg::pdirq_byte_t        host_rdata,
   input  wire logic                     line_rx_in,
   input  wire logic [4:0]               frame_start_detected,
   input  wire logic [3:0]               rx_error_event,
   input  wire logic                     link_debug_event,
   input  wire pdirq_pkg::pdirq_byte_t   tx_irq_status,
   input  wire pdirq_pkg::pdirq_byte_t   rx_irq_status,
   output logic                          line_activity_wake_status,
   output logic                          idle_clock_stop_request_enable,
   output logic                          activity_clock_start_request_enable,
   output logic                          pm_irq,
   output logic                          frame_start_irq,
   output logic                          tx_irq,
   output logic                          rx_irq,
   output logic                          rx_err_irq
);
   import pdirq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // register state

   pdirq_byte_t fs_status_r;
   pdirq_byte_t rx_err_status_r;
   pdirq_byte_t tx_enable_r;
   pdirq_byte_t rx_enable_r;
   pdirq_byte_t rx_err_enable_r;
   pdirq_byte_t pm_enable_r;
   pdirq_byte_t fs_enable_r;
   pdirq_byte_t rdata_r;
   pdirq_byte_t rdata_nxt;
   pdirq_byte_t pm_status;
   pdirq_sel_t  sel;
   logic        sel_fs_en;
   logic        act_wake_r;
   logic        act_set;
   logic        act_clear;
   logic        pm_irq_r;
   logic        fs_irq_r;
   logic        tx_irq_r;
   logic        rx_irq_r;
   logic        rx_err_irq_r;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // address decode

   always_comb begin
      sel       = PDIRQ_SEL_NONE;
      sel_fs_en = 1'b0;
      case (host_addr)
         `PDIRQ_OFS_RX_ERR_STAT: begin
            sel = PDIRQ_SEL_ERR_ST;
         end
         `PDIRQ_OFS_PM_STAT: begin
            sel = PDIRQ_SEL_PM_ST;
         end
         `PDIRQ_OFS_FS_STAT: begin
            sel = PDIRQ_SEL_FS_ST;
         end
         `PDIRQ_OFS_TX_EN: begin
            sel = PDIRQ_SEL_TX_EN;
         end
         `PDIRQ_OFS_RX_EN: begin
            sel = PDIRQ_SEL_RX_EN;
         end
         `PDIRQ_OFS_RX_ERR_EN: begin
            sel = PDIRQ_SEL_ERR_EN;
         end
         `PDIRQ_OFS_PM_EN: begin
            sel = PDIRQ_SEL_PM_EN;
         end
         `PDIRQ_OFS_FS_EN: begin
            sel_fs_en = 1'b1;
         end
         default: begin
            sel = PDIRQ_SEL_NONE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // activity wake status

   // gated async set: a cleared enable blocks the set entirely
   assign act_set   = line_rx_in & pm_enable_r[`PDIRQ_BIT_ACT_WAKE];
   assign act_clear = host_wr && (sel == PDIRQ_SEL_PM_ST)
                      && host_wdata[`PDIRQ_BIT_ACT_WAKE];

   pdirq_async_flag u_act_flag (
      .clk       (clk),
      .rst_n     (rst_n),
      .set_async (act_set),
      .clear     (act_clear),
      .flag_r    (act_wake_r)
   );

   assign pm_status = {7'h00, act_wake_r};

   ////////////////////////////////////////////////////////////////////////////////////////////
   // frame-start status

   // sets on any detected type regardless of receive enables; set wins over clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fs_status_r <= `PDIRQ_RST_VAL;
      end else begin
         fs_status_r <= ((fs_status_r
                          & ~((host_wr && (sel == PDIRQ_SEL_FS_ST)) ? host_wdata : 8'h00))
                         | {3'b000, frame_start_detected})
                        & `PDIRQ_MASK_FS;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // receive-error status

   // event bits latch strobes; debug bit re-sets while its condition stays high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_err_status_r <= `PDIRQ_RST_VAL;
      end else begin
         rx_err_status_r <= ((rx_err_status_r
                              & ~((host_wr && (sel == PDIRQ_SEL_ERR_ST)) ? host_wdata : 8'h00))
                             | {link_debug_event, 3'b000, rx_error_event})
                            & `PDIRQ_MASK_RX_ERR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // enable registers

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_enable_r <= `PDIRQ_RST_VAL;
      end else if (host_wr && (sel == PDIRQ_SEL_TX_EN)) begin
         tx_enable_r <= host_wdata & `PDIRQ_MASK_TX_EN;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_enable_r <= `PDIRQ_RST_VAL;
      end else if (host_wr && (sel == PDIRQ_SEL_RX_EN)) begin
         rx_enable_r <= host_wdata & `PDIRQ_MASK_RX_EN;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_err_enable_r <= `PDIRQ_RST_VAL;
      end else if (host_wr && (sel == PDIRQ_SEL_ERR_EN)) begin
         rx_err_enable_r <= host_wdata & `PDIRQ_MASK_RX_ERR;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pm_enable_r <= `PDIRQ_RST_VAL;
      end else if (host_wr && (sel == PDIRQ_SEL_PM_EN)) begin
         pm_enable_r <= host_wdata & `PDIRQ_MASK_PM_EN;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fs_enable_r <= `PDIRQ_RST_VAL;
      end else if (host_wr && sel_fs_en) begin
         fs_enable_r <= host_wdata & `PDIRQ_MASK_FS;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // read path

   always_comb begin
      case (sel)
         PDIRQ_SEL_ERR_ST: rdata_nxt = rx_err_status_r;
         PDIRQ_SEL_PM_ST:  rdata_nxt = pm_status;
         PDIRQ_SEL_FS_ST:  rdata_nxt = fs_status_r;
         PDIRQ_SEL_TX_EN:  rdata_nxt = tx_enable_r;
         PDIRQ_SEL_RX_EN:  rdata_nxt = rx_enable_r;
         PDIRQ_SEL_ERR_EN: rdata_nxt = rx_err_enable_r;
         PDIRQ_SEL_PM_EN:  rdata_nxt = pm_enable_r;
         default:          rdata_nxt = sel_fs_en ? fs_enable_r : 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= `PDIRQ_RST_VAL;
      end else if (host_rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // interrupt outputs

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pm_irq_r     <= 1'b0;
         fs_irq_r     <= 1'b0;
         tx_irq_r     <= 1'b0;
         rx_irq_r     <= 1'b0;
         rx_err_irq_r <= 1'b0;
      end else begin
         pm_irq_r     <= |(pm_status & pm_enable_r & `PDIRQ_MASK_PM_STAT);
         fs_irq_r     <= |(fs_status_r & fs_enable_r);
         tx_irq_r     <= |(tx_irq_status & tx_enable_r);
         rx_irq_r     <= |(rx_irq_status & rx_enable_r);
         rx_err_irq_r <= |(rx_err_status_r & rx_err_enable_r);
      end
   end

   assign host_rdata                          = rdata_r;
   assign line_activity_wake_status           = act_wake_r;
   assign idle_clock_stop_request_enable      = pm_enable_r[`PDIRQ_BIT_STOP_REQ_EN];
   assign activity_clock_start_request_enable = pm_enable_r[`PDIRQ_BIT_WAKE_REQ_EN];
   assign pm_irq                              = pm_irq_r;
   assign frame_start_irq                     = fs_irq_r;
   assign tx_irq                              = tx_irq_r;
   assign rx_irq                              = rx_irq_r;
   assign rx_err_irq                          = rx_err_irq_r;

endmodule : pdirq_top

// File: tb/pdirq_monitor.sv
// concurrent checks on the ports of the interrupt status/enable block
`timescale 1ns/1ps
module pdirq_monitor (
   input wire logic                   clk,
   input wire logic                   rst_n,
   input wire pdirq_pkg::pdirq_addr_t host_addr,
   input wire pdirq_pkg::pdirq_byte_t host_wdata,
   input wire logic                   host_wr,
   input wire logic                   host_rd,
   input wire pdirq_pkg::pdirq_byte_t host_rdata,
   input wire pdirq_pkg::pdirq_byte_t tx_irq_status,
   input wire pdirq_pkg::pdirq_byte_t rx_irq_status,
   input wire logic                   line_activity_wake_status,
   input wire logic                   idle_clock_stop_request_enable,
   input wire logic                   activity_clock_start_request_enable,
   input wire logic                   pm_irq,
   input wire logic                   tx_irq,
   input wire logic                   rx_irq
);
   import pdirq_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence rd_s(pdirq_addr_t a);
      host_rd && host_addr == a;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   pm_cause_a: assert property (pm_irq |-> $past(line_activity_wake_status))
      else $error("power irq without status");
   act_clear_a: assert property ($fell(line_activity_wake_status) |->
      $past(host_wr && host_addr == 16'h1a84 && host_wdata[0])) else $error("status lost");
   pm_rsvd_a: assert property (rd_s(16'h1a84) |=> host_rdata[7:1] == 7'h00)
      else $error("power status reserved bits set");
   err_rsvd_a: assert property (rd_s(16'h1a88) |=> host_rdata[6:4] == 3'h0)
      else $error("error enable reserved bits set");
   unmapped_rd_a: assert property (host_rd && (host_addr < 16'h1a83 ||
      host_addr > 16'h1a8a) |=> host_rdata == 8'h00) else $error("unmapped read not zero");
   tx_gate_a: assert property (tx_irq |-> $past(|tx_irq_status))
      else $error("transmit irq without status");
   rx_gate_a: assert property (rx_irq |-> $past(|rx_irq_status))
      else $error("receive irq without status");
   req_rst_a: assert property ($rose(rst_n) |-> !idle_clock_stop_request_enable &&
      !activity_clock_start_request_enable) else $error("request enables not cleared");
endmodule : pdirq_monitor

// File: tb/test_pd_mac_irq_status_enable.sv
// self-checking bench of the interrupt status/enable block
`timescale 1ns/1ps
module test_pd_mac_irq_status_enable;
   import pdirq_pkg::*;
   logic        clk, rst_n, host_wr, host_rd, line_rx_in, link_debug_event;
   logic        line_activity_wake_status, idle_clock_stop_request_enable;
   logic        activity_clock_start_request_enable, pm_irq, frame_start_irq;
   logic        tx_irq, rx_irq, rx_err_irq;
   logic [4:0]  frame_start_detected;
   logic [3:0]  rx_error_event;
   pdirq_addr_t host_addr;
   pdirq_byte_t host_wdata, host_rdata, tx_irq_status, rx_irq_status, exp_b;
   pdirq_byte_t exp_q[$];
   pdirq_byte_t msk[5] = '{8'hff, 8'hef, 8'h8f, 8'h0d, 8'h1f};
   int          miscompares, total_checks, seed, i;
   pdirq_top DUT (
      .clk                                 (clk),
      .rst_n                               (rst_n),
      .host_addr                           (host_addr),
      .host_wdata                          (host_wdata),
      .host_wr                             (host_wr),
      .host_rd                             (host_rd),
      .host_rdata                          (host_rdata),
      .line_rx_in                          (line_rx_in),
      .frame_start_detected                (frame_start_detected),
      .rx_error_event                      (rx_error_event),
      .link_debug_event                    (link_debug_event),
      .tx_irq_status                       (tx_irq_status),
      .rx_irq_status                       (rx_irq_status),
      .line_activity_wake_status           (line_activity_wake_status),
      .idle_clock_stop_request_enable      (idle_clock_stop_request_enable),
      .activity_clock_start_request_enable (activity_clock_start_request_enable),
      .pm_irq                              (pm_irq),
      .frame_start_irq                     (frame_start_irq),
      .tx_irq                              (tx_irq),
      .rx_irq                              (rx_irq),
      .rx_err_irq                          (rx_err_irq)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input pdirq_byte_t got, input pdirq_byte_t exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic w, input pdirq_addr_t a, input pdirq_byte_t d,
                      input pdirq_byte_t e);
      @(negedge clk);
      host_addr = a;
      host_wdata = d;
      host_wr = w;
      host_rd = !w;
      if (!w) exp_q.push_back(e);
      @(negedge clk);
      host_wr = 0;
      host_rd = 0;
   endtask : acc
   task automatic do_reset();
      rst_n = 0;
      repeat (5) @(negedge clk);
      rst_n = 1;
   endtask : do_reset
   task automatic final_report();
      if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   initial forever begin
      @(posedge clk);
      if (host_rd === 1'b1) begin
         @(negedge clk);
         if (exp_q.size() == 0) chk(8'h00, 8'hff);
         else chk(host_rdata, exp_q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      final_report();
   end
   initial begin
      seed = 32'hb812_283f;
      {host_wr, host_rd, line_rx_in, link_debug_event} = 4'h0;
      host_addr = 16'h0000;
      host_wdata = 8'h00;
      tx_irq_status = 8'h00;
      rx_irq_status = 8'h00;
      frame_start_detected = 5'h00;
      rx_error_event = 4'h0;
      do_reset();
      for (i = 0; i < 9; i++) acc(0, 16'(16'h1a83 + i), 0, 0);
      acc(1, 16'h0000, 8'hff, 0);
      acc(0, 16'h0000, 0, 0);
      for (i = 0; i < 5; i++) begin
         exp_b = 8'($random(seed));
         acc(1, 16'(16'h1a86 + i), exp_b, 0);
         acc(0, 16'(16'h1a86 + i), 0, exp_b & msk[i]);
      end
      acc(1, 16'h1a86, 8'h5a, 0);
      acc(1, 16'h1a87, 8'h02, 0);
      for (i = 0; i < 8; i++) begin
         @(negedge clk);
         tx_irq_status = 8'($random(seed));
         rx_irq_status = 8'($random(seed));
         @(negedge clk);
         chk({tx_irq, rx_irq}, {|(tx_irq_status & 8'h5a), |(rx_irq_status & 8'h02)});
      end
      tx_irq_status = 8'h00;
      rx_irq_status = 8'h00;
      acc(1, 16'h1a8a, 8'h00, 0);
      for (i = 0; i < 5; i++) begin
         frame_start_detected = 5'(1 << i);
         @(negedge clk);
         frame_start_detected = 5'h00;
         acc(1, 16'h1a85, 8'(~(1 << i)), 0);
         acc(0, 16'h1a85, 0, 8'(1 << i));
         chk({frame_start_irq, rx_irq}, 0);
      end
      acc(1, 16'h1a8a, 8'hff, 0);
      @(negedge clk);
      chk({frame_start_irq, rx_irq}, 2);
      acc(1, 16'h1a85, 8'h10, 0);
      @(negedge clk);
      chk(frame_start_irq, 0);
      acc(1, 16'h1a88, 8'h00, 0);
      for (i = 0; i < 4; i++) begin
         rx_error_event = 4'(1 << i);
         @(negedge clk);
         rx_error_event = 4'h0;
         acc(1, 16'h1a83, 8'(~(1 << i)), 0);
         acc(0, 16'h1a83, 0, 8'(1 << i));
         chk(rx_err_irq, 0);
      end
      acc(1, 16'h1a88, 8'hff, 0);
      @(negedge clk);
      chk(rx_err_irq, 1);
      link_debug_event = 1;
      acc(1, 16'h1a83, 8'hff, 0);
      acc(0, 16'h1a83, 0, 8'h80);
      link_debug_event = 0;
      acc(1, 16'h1a83, 8'h80, 0);
      acc(0, 16'h1a83, 0, 8'h00);
      chk(rx_err_irq, 0);
      acc(1, 16'h1a89, 8'h0c, 0);
      line_rx_in = 1;
      repeat (2) @(negedge clk);
      chk(line_activity_wake_status, 0);
      line_rx_in = 0;
      acc(1, 16'h1a89, 8'h0d, 0);
      line_rx_in = 1;
      #1 chk(line_activity_wake_status, 1);
      chk({idle_clock_stop_request_enable, activity_clock_start_request_enable}, 3);
      @(negedge clk);
      chk(pm_irq, 1);
      line_rx_in = 0;
      acc(1, 16'h1a84, 8'hfe, 0);
      acc(0, 16'h1a84, 0, 8'h01);
      acc(1, 16'h1a84, 8'h01, 0);
      @(negedge clk);
      chk({line_activity_wake_status, pm_irq}, 0);
      do_reset();
      chk({pm_irq, tx_irq, idle_clock_stop_request_enable}, 0);
      for (i = 0; i < 5; i++) acc(0, 16'(16'h1a86 + i), 0, 0);
      final_report();
   end
endmodule : test_pd_mac_irq_status_enable
bind pdirq_top pdirq_monitor u_mon (
   .clk                                 (clk),
   .rst_n                               (rst_n),
   .host_addr                           (host_addr),
   .host_wdata                          (host_wdata),
   .host_wr                             (host_wr),
   .host_rd                             (host_rd),
   .host_rdata                          (host_rdata),
   .tx_irq_status                       (tx_irq_status),
   .rx_irq_status                       (rx_irq_status),
   .line_activity_wake_status           (line_activity_wake_status),
   .idle_clock_stop_request_enable      (idle_clock_stop_request_enable),
   .activity_clock_start_request_enable (activity_clock_start_request_enable),
   .pm_irq                              (pm_irq),
   .tx_irq                              (tx_irq),
   .rx_irq                              (rx_irq)
);
